// File: ioexp_consts.vh
// Constants of the forty-line serial I/O expander.
// Assumes inclusion by bare name from the design file.
`ifndef IOEXP_CONSTS_VH
`define IOEXP_CONSTS_VH
`define IOEXP_SYS_CLK_NS 25
`define IOEXP_GLITCH_NS 50
`define IOEXP_FILT_CYC ((`IOEXP_GLITCH_NS + `IOEXP_SYS_CLK_NS - 1) / `IOEXP_SYS_CLK_NS)
`define IOEXP_ADDR_HIGH 4'h4
`define IOEXP_CMD_RESET 8'h80
`define IOEXP_CMD_AI_BIT 7
`define IOEXP_GRP_INPUT 3'h0
`define IOEXP_GRP_OUTPUT 3'h1
`define IOEXP_GRP_POLARITY 3'h2
`define IOEXP_GRP_CONFIG 3'h3
`define IOEXP_GRP_MASK 3'h4
`define IOEXP_LAST_BANK 3'h4
`define IOEXP_OUT_RESET 40'h0000000000
`define IOEXP_POL_RESET 40'h0000000000
`define IOEXP_CFG_RESET 40'hFFFFFFFFFF
`define IOEXP_MASK_RESET 40'hFFFFFFFFFF
`endif

// File: ioexp_top.v
// Forty-line I/O expander behind a two-wire serial slave interface.
// Assumes serial pins, lines and straps arrive asynchronously to sys_clk;
// the surrounding pads resolve each open-drain and two-way pin from its enable.
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.vh"

// Overview of operation
// R1: Forty lines in five banks of eight, each bank one byte.
// R2: Each line individually configured as input or driven output.
// R3: Output levels of a bank change at the acknowledge of its data byte.
// R4: Per-input mask bit keeps that input from raising the interrupt.
// R5: Per-line polarity bit inverts the value read back by the master.
// R6: Open-drain interrupt pulled low while an unmasked input has changed.
// R7: Only lines configured as inputs can raise the interrupt.
// R8: Output enable high puts every output line into high impedance.
// R9: Controller may pulse-width modulate output enable above 80 Hz.
// R10: Reset makes all forty lines inputs, so none drives.
// R11: Active-low reset returns every register and state to defaults.
// R12: Three select inputs give eight distinct slave addresses.
// R13: Slave works at both 100 kHz and 400 kHz bus clock.
// R14: Serial input glitches under 50 ns are rejected.
// R15: Last address bit one means read, zero means write.
// R16: First byte after write address is the command; low six bits point.
// R17: With auto-step set the pointer low bits advance, skipping reserved.
// R18: Command byte resets to auto-step set, lower seven bits clear.
// R19: Interrupt released on reading the bank, or input returning to read level.
module ioexp_top
(
  input wire sys_clk,
  input wire arst_n,
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire slave_sel_bit0,
  input wire slave_sel_bit1,
  input wire slave_sel_bit2,
  input wire outEnableN,
  output reg intOut,
  output reg intOe,
  input wire [7:0] lineGroup0In,
  input wire [7:0] lineGroup1In,
  input wire [7:0] lineGroup2In,
  input wire [7:0] lineGroup3In,
  input wire [7:0] lineGroup4In,
  output reg [7:0] lineGroup0Out,
  output reg [7:0] lineGroup1Out,
  output reg [7:0] lineGroup2Out,
  output reg [7:0] lineGroup3Out,
  output reg [7:0] lineGroup4Out,
  output reg [7:0] lineGroup0Oe,
  output reg [7:0] lineGroup1Oe,
  output reg [7:0] lineGroup2Oe,
  output reg [7:0] lineGroup3Oe,
  output reg [7:0] lineGroup4Oe
);

  // 40 MHz sampling gives 100 cycles per 400 kHz bus period
  localparam integer FILT_CYC = `IOEXP_FILT_CYC;
  localparam [3:0] FILT_LAST = FILT_CYC[3:0] - 4'h1; // R13
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_AACK = 9'h004;
  localparam [8:0] ST_CMD = 9'h008;
  localparam [8:0] ST_CACK = 9'h010;
  localparam [8:0] ST_WDAT = 9'h020;
  localparam [8:0] ST_WACK = 9'h040;
  localparam [8:0] ST_RDAT = 9'h080;
  localparam [8:0] ST_RACK = 9'h100;

  // Two-flop synchronisers for every asynchronous input
  wire [39:0] lineRaw = {lineGroup4In, lineGroup3In, lineGroup2In, lineGroup1In, lineGroup0In};
  wire [5:0] miscRaw = {outEnableN, slave_sel_bit2, slave_sel_bit1, slave_sel_bit0, sdaIn, sclIn};
  reg [39:0] lineMeta_q;
  reg [39:0] lineSync_q;
  reg [5:0] miscMeta_q;
  reg [5:0] miscSync_q;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lineMeta_q <= 40'h0000000000;
      lineSync_q <= 40'h0000000000;
      miscMeta_q <= 6'h23;
      miscSync_q <= 6'h23;
    end
    else
    begin
      lineMeta_q <= lineRaw;
      lineSync_q <= lineMeta_q;
      miscMeta_q <= miscRaw;
      miscSync_q <= miscMeta_q;
    end
  end

  // Glitch filter: a level is accepted only after it holds for the filter width
  // One level register per pin, so each has a single driver
  wire [1:0] busFilt;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : gFilt
      reg [3:0] holdCnt_q;
      reg level_q;
      assign busFilt[gi] = level_q;
      always @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          holdCnt_q <= 4'h0;
          level_q <= 1'b1;
        end
        else if (miscSync_q[gi] == level_q)
          holdCnt_q <= 4'h0;
        else if (holdCnt_q == FILT_LAST)
        begin
          holdCnt_q <= 4'h0;
          level_q <= miscSync_q[gi]; // R14
        end
        else
          holdCnt_q <= holdCnt_q + 4'h1;
      end
    end
  endgenerate

  reg sclPrev_q;
  reg sdaPrev_q;
  wire scl = busFilt[0];
  wire sda = busFilt[1];
  wire sclRise = scl & ~sclPrev_q;
  wire sclFall = ~scl & sclPrev_q;
  wire startCond = scl & sclPrev_q & sdaPrev_q & ~sda;
  wire stopCond = scl & sclPrev_q & ~sdaPrev_q & sda;
  wire [6:0] myAddr = {`IOEXP_ADDR_HIGH, miscSync_q[4:2]}; // R12

  // Device registers, one bit per line
  reg [39:0] outReg_q;
  reg [39:0] polReg_q;
  reg [39:0] cfgReg_q;
  reg [39:0] maskReg_q;
  reg [39:0] lastRead_q;
  reg [7:0] cmd_q;
  reg [2:0] primeSh_q;

  reg [8:0] state_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg [7:0] txByte_q;
  reg readDir_q;
  reg wrAccept_q;

  wire [2:0] ptrGrp = cmd_q[5:3];
  wire [2:0] ptrBank = cmd_q[2:0];
  wire [7:0] rxByte = shift_q;
  wire [39:0] readIn = lineSync_q ^ polReg_q; // R5

  // Pointer after one byte, wrapping past the reserved banks
  function [2:0] stepBank;
    input [2:0] bank;
    input autoStep;
    begin
      if (!autoStep)
        stepBank = bank;
      else if (bank >= `IOEXP_LAST_BANK)
        stepBank = 3'h0; // R17
      else
        stepBank = bank + 3'h1; // R17
    end
  endfunction

  function [7:0] readByte;
    input [2:0] grp;
    input [2:0] bank;
    input [39:0] inV;
    input [39:0] outV;
    input [39:0] polV;
    input [39:0] cfgV;
    input [39:0] mskV;
    begin
      readByte = 8'h00;
      if (bank <= `IOEXP_LAST_BANK)
      begin
        case (grp)
          `IOEXP_GRP_INPUT: readByte = inV[bank * 8 +: 8];
          `IOEXP_GRP_OUTPUT: readByte = outV[bank * 8 +: 8];
          `IOEXP_GRP_POLARITY: readByte = polV[bank * 8 +: 8];
          `IOEXP_GRP_CONFIG: readByte = cfgV[bank * 8 +: 8];
          `IOEXP_GRP_MASK: readByte = mskV[bank * 8 +: 8];
          default: readByte = 8'h00;
        endcase
      end
    end
  endfunction

  wire [2:0] nextBank = stepBank(ptrBank, cmd_q[`IOEXP_CMD_AI_BIT]);
  wire [7:0] curRead = readByte(ptrGrp, ptrBank, readIn, outReg_q, polReg_q, cfgReg_q, maskReg_q);
  wire [7:0] nextRead = readByte(ptrGrp, nextBank, readIn, outReg_q, polReg_q, cfgReg_q,
    maskReg_q);
  // Input banks are read-only, so a write there is not acknowledged
  wire wrValid = (ptrBank <= `IOEXP_LAST_BANK) && (ptrGrp != `IOEXP_GRP_INPUT) &&
    (ptrGrp <= `IOEXP_GRP_MASK);
  wire [2:0] loadBank = (state_q == ST_AACK) ? ptrBank : nextBank;
  wire inputLoad = (ptrGrp == `IOEXP_GRP_INPUT) && (loadBank <= `IOEXP_LAST_BANK) &&
    (((state_q == ST_AACK) && sclFall && readDir_q) ||
    ((state_q == ST_RACK) && sclRise && !sda));

  // Serial slave engine
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE; // R11
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      txByte_q <= 8'h00;
      readDir_q <= 1'b0;
      wrAccept_q <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      cmd_q <= `IOEXP_CMD_RESET; // R18
      outReg_q <= `IOEXP_OUT_RESET;
      polReg_q <= `IOEXP_POL_RESET;
      cfgReg_q <= `IOEXP_CFG_RESET; // R10
      maskReg_q <= `IOEXP_MASK_RESET;
    end
    else
    begin
      sclPrev_q <= scl;
      sdaPrev_q <= sda;
      sdaOut <= 1'b0;
      if (stopCond)
      begin
        state_q <= ST_IDLE;
        sdaOe <= 1'b0;
      end
      else if (startCond)
      begin
        state_q <= ST_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe <= 1'b0;
      end
      else if (sclRise)
      begin
        case (state_q)
          ST_ADDR, ST_CMD, ST_WDAT:
          begin
            shift_q <= {shift_q[6:0], sda};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          ST_RDAT:
            bitCnt_q <= bitCnt_q + 4'h1;
          ST_RACK:
          begin
            if (!sda)
            begin
              cmd_q[2:0] <= nextBank; // R17
              txByte_q <= nextRead;
              bitCnt_q <= 4'h0;
              state_q <= ST_RDAT;
            end
            else
              state_q <= ST_IDLE;
          end
          default:
            state_q <= state_q;
        endcase
      end
      else if (sclFall)
      begin
        case (state_q)
          ST_ADDR:
          begin
            if (bitCnt_q == 4'h8)
            begin
              if (shift_q[7:1] == myAddr)
              begin
                readDir_q <= shift_q[0]; // R15
                sdaOe <= 1'b1;
                state_q <= ST_AACK;
              end
              else
                state_q <= ST_IDLE;
            end
          end
          ST_AACK:
          begin
            bitCnt_q <= 4'h0;
            if (readDir_q)
            begin
              txByte_q <= curRead;
              sdaOe <= ~curRead[7];
              state_q <= ST_RDAT;
            end
            else
            begin
              sdaOe <= 1'b0;
              state_q <= ST_CMD;
            end
          end
          ST_CMD:
          begin
            if (bitCnt_q == 4'h8)
            begin
              cmd_q <= rxByte; // R16
              sdaOe <= 1'b1;
              state_q <= ST_CACK;
            end
          end
          ST_CACK:
          begin
            sdaOe <= 1'b0;
            bitCnt_q <= 4'h0;
            state_q <= ST_WDAT;
          end
          ST_WDAT:
          begin
            if (bitCnt_q == 4'h8)
            begin
              wrAccept_q <= wrValid;
              sdaOe <= wrValid;
              state_q <= ST_WACK;
              if (wrValid)
              begin
                case (ptrGrp)
                  `IOEXP_GRP_OUTPUT: outReg_q[ptrBank * 8 +: 8] <= rxByte; // R3
                  `IOEXP_GRP_POLARITY: polReg_q[ptrBank * 8 +: 8] <= rxByte;
                  `IOEXP_GRP_CONFIG: cfgReg_q[ptrBank * 8 +: 8] <= rxByte; // R2
                  default: maskReg_q[ptrBank * 8 +: 8] <= rxByte; // R4
                endcase
              end
            end
          end
          ST_WACK:
          begin
            sdaOe <= 1'b0;
            bitCnt_q <= 4'h0;
            if (wrAccept_q)
              cmd_q[2:0] <= nextBank; // R17
            state_q <= ST_WDAT;
          end
          ST_RDAT:
          begin
            if (bitCnt_q == 4'h8)
            begin
              sdaOe <= 1'b0;
              state_q <= ST_RACK;
            end
            else
              sdaOe <= ~txByte_q[3'h7 - bitCnt_q[2:0]];
          end
          default:
            state_q <= state_q;
        endcase
      end
    end
  end

  // Change detection against the level last read by the master
  wire [39:0] changed = (lineSync_q ^ lastRead_q) & cfgReg_q & ~maskReg_q; // R4 R7

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      primeSh_q <= 3'h0;
      lastRead_q <= 40'h0000000000;
      intOe <= 1'b0;
      intOut <= 1'b0;
    end
    else
    begin
      primeSh_q <= {primeSh_q[1:0], 1'b1};
      intOut <= 1'b0;
      // Reference follows the pins until the synchronisers hold real levels,
      // so the reset value of the sync flops cannot fake a change
      if (!primeSh_q[2])
        lastRead_q <= lineSync_q;
      else if (inputLoad)
        lastRead_q[loadBank * 8 +: 8] <= lineSync_q[loadBank * 8 +: 8]; // R19
      intOe <= primeSh_q[2] && (|changed); // R6 R19
    end
  end

  // Line drivers: output enable pin gates every configured output
  wire outAllowed = ~miscSync_q[5];
  wire [39:0] lineOeNext = ~cfgReg_q & {40{outAllowed}}; // R8 R9

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {lineGroup4Out, lineGroup3Out, lineGroup2Out, lineGroup1Out, lineGroup0Out} <=
        `IOEXP_OUT_RESET;
      {lineGroup4Oe, lineGroup3Oe, lineGroup2Oe, lineGroup1Oe, lineGroup0Oe} <=
        40'h0000000000; // R10
    end
    else
    begin
      {lineGroup4Out, lineGroup3Out, lineGroup2Out, lineGroup1Out, lineGroup0Out} <=
        outReg_q; // R1 R3
      {lineGroup4Oe, lineGroup3Oe, lineGroup2Oe, lineGroup1Oe, lineGroup0Oe} <=
        lineOeNext; // R2
    end
  end


endmodule // ioexp_top
`default_nettype wire

// File: ioexp_chk.sv
// Checker on the pins of the forty-line expander.
// Assumes binding to ioexp_top; it reads ports only.
`timescale 1ns/1ps
`default_nettype none
module ioexp_chk
(
  input wire sys_clk,
  input wire arst_n,
  input wire sclIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire outEnableN,
  input wire intOut,
  input wire intOe,
  input wire [7:0] lineGroup0In,
  input wire [7:0] lineGroup1In,
  input wire [7:0] lineGroup2In,
  input wire [7:0] lineGroup3In,
  input wire [7:0] lineGroup4In,
  input wire [7:0] lineGroup0Out,
  input wire [7:0] lineGroup1Out,
  input wire [7:0] lineGroup2Out,
  input wire [7:0] lineGroup3Out,
  input wire [7:0] lineGroup4Out,
  input wire [7:0] lineGroup0Oe,
  input wire [7:0] lineGroup1Oe,
  input wire [7:0] lineGroup2Oe,
  input wire [7:0] lineGroup3Oe,
  input wire [7:0] lineGroup4Oe
);
  wire [39:0] ins = {lineGroup4In, lineGroup3In, lineGroup2In, lineGroup1In, lineGroup0In};
  wire [39:0] outs = {lineGroup4Out, lineGroup3Out, lineGroup2Out, lineGroup1Out, lineGroup0Out};
  wire [39:0] oes = {lineGroup4Oe, lineGroup3Oe, lineGroup2Oe, lineGroup1Oe, lineGroup0Oe};
  reg [3:0] quietCnt_q;
  reg ackSeen_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Quiet span: no pin or bus edge, so nothing may move the interrupt
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      quietCnt_q <= 4'h0;
      ackSeen_q <= 1'b0;
    end
    else
    begin
      quietCnt_q <= (!$stable(ins) || !$stable(sclIn)) ? 4'h0 :
        quietCnt_q + {3'h0, quietCnt_q != 4'hF};
      ackSeen_q <= ackSeen_q | sdaOe;
    end
  property p_oeGate;
    (|oes) |-> !$past(outEnableN, 3);
  endproperty
  a_oeGate: assert property (p_oeGate) else $error("line drives while disabled");
  property p_rstLines;
    $rose(arst_n) |-> oes == 40'h0 && outs == 40'h0;
  endproperty
  a_rstLines: assert property (p_rstLines) else $error("lines not idle after reset");
  property p_rstInt;
    $rose(arst_n) |-> !intOe && !sdaOe ##1 !intOe;
  endproperty
  a_rstInt: assert property (p_rstInt) else $error("pins active after reset");
  property p_outAtAck;
    !$stable(outs) |-> sdaOe;
  endproperty
  a_outAtAck: assert property (p_outAtAck) else $error("output moved off ack");
  property p_intQuiet;
    quietCnt_q >= 4'hA |-> $stable(intOe);
  endproperty
  a_intQuiet: assert property (p_intQuiet) else $error("interrupt moved without cause");
  property p_openDrain;
    sdaOut == 1'b0 && intOut == 1'b0;
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("open drain drives high");
  // Answer lands a few cycles after the bus clock fall
  property p_sdaTiming;
    !$stable(sdaOe) |-> !$past(sclIn, 4) || !$past(sclIn, 5) || !$past(sclIn, 6);
  endproperty
  a_sdaTiming: assert property (p_sdaTiming) else $error("data moved off clock low");
  property p_maskRst;
    !ackSeen_q |-> !intOe;
  endproperty
  a_maskRst: assert property (p_maskRst) else $error("interrupt while all masked");
endmodule // ioexp_chk
bind ioexp_top ioexp_chk i_chk (.*);
`default_nettype wire

// File: ioexp_mst.sv
// Serial bus master model for the expander's clock and data pins.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ioexp_mst
(
  input wire logic sys_clk,
  input wire logic sdaIn,
  output logic sclIn,
  output logic sdaLow
);
  // Clock stands high between frames
  initial
  begin
    sclIn = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic halfBit;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic waitE(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Sampled late in the high phase: the slave answers after its own sync delay
  task automatic bitX(input logic b, output logic r);
    // Low phase outlasts the slave's five-cycle answer; period stays 200 ns
    sdaLow = ~b;
    waitE(5);
    sclIn = 1'b1;
    waitE(3);
    r = sdaIn;
    sclIn = 1'b0;
  endtask
  task automatic byteX(input logic [7:0] d, input logic mAck, output logic [7:0] q,
    output logic nk);
    for (int i = 7; i >= 0; i--)
      bitX(d[i], q[i]);
    bitX(mAck, nk);
  endtask
  task automatic startC;
    sdaLow = 1'b0;
    waitE(5);
    sclIn = 1'b1;
    halfBit();
    sdaLow = 1'b1;
    halfBit();
    sclIn = 1'b0;
  endtask
  task automatic stopC;
    sdaLow = 1'b1;
    halfBit();
    sclIn = 1'b1;
    halfBit();
    sdaLow = 1'b0;
    halfBit();
  endtask
  // One-cycle clock pulse inside a low phase, shorter than the filter
  task automatic glitch;
    waitE(2);
    sclIn = 1'b1;
    waitE(1);
    sclIn = 1'b0;
  endtask
endmodule // ioexp_mst
`default_nettype wire

// File: ioexp_tb.sv
// Self-checking bench for the expander with a bus master model.
// Assumes ioexp_top, ioexp_mst and the bound checker compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin nMismatch++; \
  $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic outEnableN = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [39:0] pins = 40'h5A3C96E1F0;
  wire [39:0] outs;
  wire [39:0] oes;
  wire sclIn;
  wire sdaLow;
  wire sdaOe;
  wire intOe;
  wire sdaIn = ~(sdaLow | sdaOe);
  int nMismatch = 0;
  int nCompared = 0;
  always #12.5 sys_clk = ~sys_clk;
  ioexp_top i_dut
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(),
    .sdaOe(sdaOe),
    .slave_sel_bit0(sel[0]),
    .slave_sel_bit1(sel[1]),
    .slave_sel_bit2(sel[2]),
    .outEnableN(outEnableN),
    .intOut(),
    .intOe(intOe),
    .lineGroup0In(pins[7:0]),
    .lineGroup1In(pins[15:8]),
    .lineGroup2In(pins[23:16]),
    .lineGroup3In(pins[31:24]),
    .lineGroup4In(pins[39:32]),
    .lineGroup0Out(outs[7:0]),
    .lineGroup1Out(outs[15:8]),
    .lineGroup2Out(outs[23:16]),
    .lineGroup3Out(outs[31:24]),
    .lineGroup4Out(outs[39:32]),
    .lineGroup0Oe(oes[7:0]),
    .lineGroup1Oe(oes[15:8]),
    .lineGroup2Oe(oes[23:16]),
    .lineGroup3Oe(oes[31:24]),
    .lineGroup4Oe(oes[39:32])
  );
  ioexp_mst i_mst
  (
    .sys_clk(sys_clk),
    .sdaIn(sdaIn),
    .sclIn(sclIn),
    .sdaLow(sdaLow)
  );
  task automatic testDone;
    $display("Compared %0d, mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic waitC(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic sendB(input logic [7:0] d, input logic ack);
    logic [7:0] q;
    logic nk;
    i_mst.byteX(d, 1'b1, q, nk);
    `CHK(nk, ~ack)
  endtask
  task automatic readB(input logic [7:0] e, input logic last);
    logic [7:0] q;
    logic nk;
    i_mst.byteX(8'hFF, last, q, nk);
    `CHK(q, e)
  endtask
  task automatic startRw(input logic rw);
    i_mst.startC();
    sendB({4'h4, sel, rw}, 1'b1);
  endtask
  task automatic pinChk(input int b, input logic e);
    pins[b] = ~pins[b];
    waitC(12);
    `CHK(intOe, e)
  endtask
  initial
  begin
    waitC(12);
    arst_n = 1'b1;
    waitC(8);
    `CHK({oes, outs}, 80'h0)
    startRw(1'b1);
    readB(pins[7:0], 1'b0);
    readB(pins[15:8], 1'b1);
    i_mst.stopC();
    for (int a = 0; a < 8; a++)
    begin
      sel = a[2:0];
      i_mst.startC();
      sendB({4'h4, sel ^ 3'h1, 1'b0}, 1'b0);
      startRw(1'b0);
      i_mst.stopC();
    end
    startRw(1'b0);
    sendB(8'h88, 1'b1);
    i_mst.glitch();
    sendB(8'h55, 1'b1);
    sendB(8'hAA, 1'b1);
    startRw(1'b0);
    sendB(8'h98, 1'b1);
    sendB(8'h00, 1'b1);
    sendB(8'h0F, 1'b1);
    i_mst.stopC();
    `CHK({oes[15:0], outs[15:0]}, 32'hF0FFAA55)
    outEnableN = 1'b1;
    waitC(4);
    `CHK(oes[15:0], 16'h0000)
    outEnableN = 1'b0;
    startRw(1'b0);
    sendB(8'h01, 1'b1);
    sendB(8'h33, 1'b0);
    startRw(1'b0);
    sendB(8'h0D, 1'b1);
    sendB(8'h33, 1'b0);
    startRw(1'b0);
    sendB(8'h12, 1'b1);
    sendB(8'hF0, 1'b1);
    startRw(1'b0);
    sendB(8'h02, 1'b1);
    startRw(1'b1);
    readB(pins[23:16] ^ 8'hF0, 1'b0);
    readB(pins[23:16] ^ 8'hF0, 1'b1);
    startRw(1'b0);
    sendB(8'hA0, 1'b1);
    sendB(8'h00, 1'b1);
    sendB(8'hFE, 1'b1);
    i_mst.stopC();
    pinChk(3, 1'b0);
    pinChk(9, 1'b0);
    pinChk(8, 1'b1);
    pinChk(8, 1'b0);
    pinChk(8, 1'b1);
    startRw(1'b0);
    sendB(8'h01, 1'b1);
    startRw(1'b1);
    readB(pins[15:8], 1'b1);
    i_mst.stopC();
    `CHK(intOe, 1'b0)
    arst_n = 1'b0;
    waitC(3);
    arst_n = 1'b1;
    waitC(8);
    `CHK({oes, outs, intOe}, 81'h0)
    startRw(1'b1);
    readB(pins[7:0], 1'b1);
    i_mst.stopC();
    // Unread bank unmasked after reset must not look changed
    startRw(1'b0);
    sendB(8'h24, 1'b1);
    sendB(8'h00, 1'b1);
    i_mst.stopC();
    waitC(8);
    `CHK(intOe, 1'b0)
    testDone();
  end
  // Run takes about 115 us; the bound leaves ample margin
  initial
  begin
    #500000;
    nMismatch++;
    testDone();
  end
endmodule // testbench
`default_nettype wire
